// ===== src/prss_top.sv
// rail enables, buck sequencing, status flags and status-link sender
// comparator results, CHIP_ENABLE and the link pin arrive asynchronous and are synchronised
`timescale 1ns/100ps
`include "prss_regs.svh"
module prss_top #(
    parameter int BUCK_START_CYC = `PRSS_BUCK_START_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic CHIP_ENABLE,
    input wire logic SLEEP_REQ,
    input wire logic VARIANT_AMP,
    input wire logic CMP_BUCK_OC,
    input wire logic CMP_BUCK_BELOW90,
    input wire logic CMP_BUCK_ABOVE94,
    input wire logic CMP_BUCK_BELOW80,
    input wire logic CMP_SUPPLY_OV_STOP,
    input wire logic CMP_BUCK_IN_UV,
    input wire logic CMP_FB_EXT_HELD,
    input wire logic CMP_SUPPLY_12V_BAND,
    input wire logic CMP_SUPPLY_LOW_CP,
    input wire logic STATUS_LINK_PIN_I,
    output logic STATUS_LINK_PIN_O,
    output logic STATUS_LINK_PIN_OE_N,
    output logic LDO5_EN,
    output logic LDO12_EN,
    output logic BUCK_EN,
    output logic CHARGE_PUMP_EN,
    output logic CURRENT_LIMIT_FAULT_OUT_N,
    output logic [7:0] STATUS_REGISTER_ZERO,
    output logic MSG_PENDING
);
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;

    assign async_in = {STATUS_LINK_PIN_I, CMP_SUPPLY_LOW_CP,
        CMP_SUPPLY_12V_BAND, CMP_FB_EXT_HELD, CMP_BUCK_IN_UV,
        CMP_SUPPLY_OV_STOP, CMP_BUCK_BELOW80, CMP_BUCK_ABOVE94,
        CMP_BUCK_BELOW90, CMP_BUCK_OC, CHIP_ENABLE};

    // two-stage synchronisers, first stage feeds only the second
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++) begin : g_sync
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                end else if (CLK_EN) begin
                    s1_q[g] <= async_in[g];
                    s2_q[g] <= s1_q[g];
                end
            end
        end
    endgenerate

    logic ce_s, oc_s, b90_s, a94_s, b80_s, ov_s, inuv_s, fbx_s;
    logic band_s, cplow_s, link_s;
    assign ce_s = s2_q[0];
    assign oc_s = s2_q[1];
    assign b90_s = s2_q[2];
    assign a94_s = s2_q[3];
    assign b80_s = s2_q[4];
    assign ov_s = s2_q[5];
    assign inuv_s = s2_q[6];
    assign fbx_s = s2_q[7];
    assign band_s = s2_q[8];
    assign cplow_s = s2_q[9];
    assign link_s = s2_q[10];

    // sleep and variant are from same-clock logic, no synchroniser
    logic sleep_st, standby_st, buck_stop;
    assign sleep_st = ~ce_s & SLEEP_REQ;
    assign standby_st = ~ce_s & ~SLEEP_REQ;
    assign buck_stop = ov_s | inuv_s | fbx_s;

    prss_pkg::prss_seq_t seq_q;
    logic [23:0] start_cnt_q;
    logic uvf_q;

    // buck comes up and settles before the 5V regulator is allowed on
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            seq_q <= prss_pkg::SEQ_OFF;
            start_cnt_q <= 24'h00_0000;
        end else if (CLK_EN) begin
            case (seq_q)
                prss_pkg::SEQ_OFF: begin
                    if (!sleep_st && !buck_stop) begin
                        start_cnt_q <= 24'(BUCK_START_CYC);
                        seq_q <= prss_pkg::SEQ_BUCK_START;
                    end
                end
                prss_pkg::SEQ_BUCK_START: begin
                    if (sleep_st || buck_stop) begin
                        seq_q <= prss_pkg::SEQ_OFF;
                    end else if (b80_s && start_cnt_q == 24'h00_0000) begin
                        seq_q <= prss_pkg::SEQ_FAULT;
                    end else if (start_cnt_q == 24'h00_0000) begin
                        seq_q <= prss_pkg::SEQ_RUN;
                    end else begin
                        start_cnt_q <= start_cnt_q - 24'h00_0001;
                    end
                end
                prss_pkg::SEQ_RUN: begin
                    if (b80_s) begin
                        seq_q <= prss_pkg::SEQ_FAULT;
                    end else if (sleep_st || buck_stop) begin
                        seq_q <= prss_pkg::SEQ_OFF;
                    end
                end
                prss_pkg::SEQ_FAULT: begin
                    // latched shutdown; leave only through sleep
                    if (sleep_st) begin
                        seq_q <= prss_pkg::SEQ_OFF;
                    end
                end
                default: seq_q <= prss_pkg::SEQ_OFF;
            endcase
        end
    end

    logic buck_on_d, ldo5_d, ldo12_d, cp_d;
    assign buck_on_d = (seq_q == prss_pkg::SEQ_BUCK_START) ||
        (seq_q == prss_pkg::SEQ_RUN);
    assign ldo5_d = (seq_q == prss_pkg::SEQ_RUN) && !sleep_st &&
        !(standby_st && VARIANT_AMP);
    assign ldo12_d = ce_s && (seq_q != prss_pkg::SEQ_FAULT);
    assign cp_d = ldo12_d && cplow_s && !band_s;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BUCK_EN <= 1'b0;
            LDO5_EN <= 1'b0;
            LDO12_EN <= 1'b0;
            CHARGE_PUMP_EN <= 1'b0;
        end else if (CLK_EN) begin
            BUCK_EN <= buck_on_d;
            LDO5_EN <= ldo5_d;
            LDO12_EN <= ldo12_d;
            CHARGE_PUMP_EN <= cp_d;
        end
    end

    // status flags; comparators are level, uv warning holds hysteresis
    logic ocw_q, uvw_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ocw_q <= 1'b0;
            uvw_q <= 1'b0;
            uvf_q <= 1'b0;
        end else if (CLK_EN) begin
            ocw_q <= oc_s;
            if (b90_s) begin
                uvw_q <= 1'b1;
            end else if (a94_s) begin
                uvw_q <= 1'b0;
            end
            // fault sticks until sleep restarts the rails
            // latched shutdown also covers a start that never reached 80%
            if ((b80_s && seq_q == prss_pkg::SEQ_RUN) || inuv_s ||
                seq_q == prss_pkg::SEQ_FAULT) begin
                uvf_q <= 1'b1;
            end else if (sleep_st) begin
                uvf_q <= 1'b0;
            end
        end
    end

    logic [7:0] st0_d;
    always_comb begin
        st0_d = `PRSS_ST0_RESET;
        st0_d[`PRSS_ST0_OC_WARN] = ocw_q;
        st0_d[`PRSS_ST0_UV_WARN] = uvw_q;
        st0_d[`PRSS_ST0_UV_FAULT] = uvf_q;
    end

    logic [7:0] st0_prev_q;
    logic [`PRSS_QCNT_W-1:0] qcnt_q;
    logic tx_busy, tx_low, tx_start_q, chg;
    assign chg = (st0_d != st0_prev_q);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st0_prev_q <= `PRSS_ST0_RESET;
            STATUS_REGISTER_ZERO <= `PRSS_ST0_RESET;
        end else if (CLK_EN) begin
            st0_prev_q <= st0_d;
            STATUS_REGISTER_ZERO <= st0_d;
        end
    end

    // counts pending messages; each flag change adds one, saturating
    // at the top is the only loss, sized well above realistic bursts
    logic take;
    assign take = tx_start_q && !tx_busy && link_s;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            qcnt_q <= '0;
        end else if (CLK_EN) begin
            if (chg && !take && qcnt_q != '1) begin
                qcnt_q <= qcnt_q + 1'b1;
            end else if (!chg && take) begin
                qcnt_q <= qcnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_start_q <= 1'b0;
            MSG_PENDING <= 1'b0;
        end else if (CLK_EN) begin
            tx_start_q <= (qcnt_q != '0) && !take;
            MSG_PENDING <= (qcnt_q != '0);
        end
    end

    // message byte is the current register snapshot with its id
    prss_uart_tx u_tx (
        .clk(CLK),
        .rst(RST),
        .ce(CLK_EN),
        .start(tx_start_q),
        .byte_in(`PRSS_ST0_MSG_ID | st0_d),
        .line_idle(link_s),
        .busy(tx_busy),
        .line_low(tx_low)
    );

    // open drain: pin output always low, enable (active low) selects drive
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            STATUS_LINK_PIN_O <= 1'b0;
            STATUS_LINK_PIN_OE_N <= 1'b1;
            CURRENT_LIMIT_FAULT_OUT_N <= 1'b1;
        end else if (CLK_EN) begin
            STATUS_LINK_PIN_O <= 1'b0;
            STATUS_LINK_PIN_OE_N <= ~tx_low;
            CURRENT_LIMIT_FAULT_OUT_N <= ~uvf_q;
        end
    end
endmodule

// ===== src/prss_regs.svh
// constants for the power rail supervisor: field positions, resets, timing
// assumes a 100 MHz clock; included by the modules, not by the package
`ifndef PRSS_REGS_SVH
`define PRSS_REGS_SVH

`define PRSS_CLK_HZ 100000000
`define PRSS_BAUD 9600
`define PRSS_BIT_CYC (`PRSS_CLK_HZ / `PRSS_BAUD)
`define PRSS_DATA_BITS 8
`define PRSS_BUCK_START_US 100
`define PRSS_BUCK_START_CYC (`PRSS_BUCK_START_US * (`PRSS_CLK_HZ / 1000000))
`define PRSS_QCNT_W 4

`define PRSS_ST0_OC_WARN 0
`define PRSS_ST0_UV_WARN 1
`define PRSS_ST0_UV_FAULT 2
// message id value is arbitrary
`define PRSS_ST0_MSG_ID 8'hA0
`define PRSS_ST0_RESET 8'h00

`endif

// ===== src/prss_pkg.sv
// types shared by the power rail supervisor modules
// constants live in prss_regs.svh
package prss_pkg;
    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_BUCK_START,
        SEQ_RUN,
        SEQ_FAULT
    } prss_seq_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } prss_tx_t;
endpackage

// ===== src/prss_uart_tx.sv
// serial transmitter for the open-drain status link
// caller holds byte stable while start is high and busy low
`timescale 1ns/100ps
`include "prss_regs.svh"
module prss_uart_tx (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic [7:0] byte_in,
    input wire logic line_idle,
    output logic busy,
    output logic line_low
);
    localparam int BIT_CYC = `PRSS_BIT_CYC;
    prss_pkg::prss_tx_t st_q;
    logic [13:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;

    assign busy = (st_q != prss_pkg::TX_IDLE);

    // one byte frame: start low, lsb first, stop high, no parity
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= prss_pkg::TX_IDLE;
            cnt_q <= 14'h0000;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            line_low <= 1'b0;
        end else if (ce) begin
            case (st_q)
                prss_pkg::TX_IDLE: begin
                    line_low <= 1'b0;
                    // half duplex: never start over a host frame
                    if (start && line_idle) begin
                        sh_q <= byte_in;
                        cnt_q <= 14'(BIT_CYC - 1);
                        line_low <= 1'b1;
                        st_q <= prss_pkg::TX_START;
                    end
                end
                prss_pkg::TX_START: begin
                    if (cnt_q == 14'h0000) begin
                        cnt_q <= 14'(BIT_CYC - 1);
                        bit_q <= 3'h0;
                        line_low <= ~sh_q[0];
                        st_q <= prss_pkg::TX_DATA;
                    end else begin
                        cnt_q <= cnt_q - 14'h0001;
                    end
                end
                prss_pkg::TX_DATA: begin
                    if (cnt_q == 14'h0000) begin
                        cnt_q <= 14'(BIT_CYC - 1);
                        if (bit_q == 3'h7) begin
                            line_low <= 1'b0;
                            st_q <= prss_pkg::TX_STOP;
                        end else begin
                            bit_q <= bit_q + 3'h1;
                            line_low <= ~sh_q[bit_q + 3'h1];
                        end
                    end else begin
                        cnt_q <= cnt_q - 14'h0001;
                    end
                end
                prss_pkg::TX_STOP: begin
                    if (cnt_q == 14'h0000) begin
                        st_q <= prss_pkg::TX_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 14'h0001;
                    end
                end
                default: st_q <= prss_pkg::TX_IDLE;
            endcase
        end
    end
endmodule

// ===== verif/prss_checker.sv
// port-level assertions for the power rail supervisor top
// bound to prss_top from the bench top file; one clock, reset high
`timescale 1ns/100ps
`include "prss_regs.svh"
module prss_checker #(
    parameter int BUCK_START_CYC = 20
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CHIP_ENABLE,
    input wire logic SLEEP_REQ,
    input wire logic VARIANT_AMP,
    input wire logic CMP_BUCK_OC,
    input wire logic CMP_BUCK_BELOW90,
    input wire logic CMP_BUCK_ABOVE94,
    input wire logic CMP_BUCK_BELOW80,
    input wire logic CMP_SUPPLY_OV_STOP,
    input wire logic CMP_BUCK_IN_UV,
    input wire logic CMP_FB_EXT_HELD,
    input wire logic CMP_SUPPLY_12V_BAND,
    input wire logic STATUS_LINK_PIN_I,
    input wire logic STATUS_LINK_PIN_O,
    input wire logic STATUS_LINK_PIN_OE_N,
    input wire logic LDO5_EN,
    input wire logic LDO12_EN,
    input wire logic BUCK_EN,
    input wire logic CHARGE_PUMP_EN,
    input wire logic CURRENT_LIMIT_FAULT_OUT_N,
    input wire logic [7:0] STATUS_REGISTER_ZERO,
    input wire logic MSG_PENDING
);
    logic [15:0] buck_cnt_q;
    // one cycle of slack for the design's own counter phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            buck_cnt_q <= 16'h0000;
        end else if (!BUCK_EN) begin
            buck_cnt_q <= 16'h0000;
        end else if (buck_cnt_q != 16'hffff) begin
            buck_cnt_q <= buck_cnt_q + 16'h0001;
        end
    end
    // released cycles since last pull; a frame's longest gap is 9 bits
    localparam int QUIET_CYC = 10 * `PRSS_BIT_CYC;
    logic [19:0] quiet_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            quiet_q <= 20'h0_0000;
        end else if (!STATUS_LINK_PIN_OE_N) begin
            quiet_q <= 20'h0_0000;
        end else if (quiet_q != 20'hF_FFFF) begin
            quiet_q <= quiet_q + 20'h0_0001;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_sleep_ldo5_off: assert property ((!CHIP_ENABLE && SLEEP_REQ)[*5]
        |-> !LDO5_EN) else $error("ldo5 on in sleep");
    a_amp_standby_off: assert property ((!CHIP_ENABLE && VARIANT_AMP)[*5]
        |-> !LDO5_EN) else $error("ldo5 on in amp standby");
    a_ce_ldo12_off: assert property ((!CHIP_ENABLE)[*5] |-> !LDO12_EN)
        else $error("ldo12 on without chip enable");
    a_buck_first: assert property ($rose(LDO5_EN) |-> BUCK_EN
        && buck_cnt_q >= BUCK_START_CYC - 1) else $error("ldo5 before buck");
    a_band_pump_off: assert property (CMP_SUPPLY_12V_BAND[*5]
        |-> !CHARGE_PUMP_EN) else $error("pump on in 12V band");
    a_oc_warn_set: assert property (CMP_BUCK_OC[*5]
        |-> STATUS_REGISTER_ZERO[0]) else $error("oc warn missing");
    a_oc_warn_clear: assert property ((!CMP_BUCK_OC)[*5]
        |-> !STATUS_REGISTER_ZERO[0]) else $error("oc warn stuck");
    a_uv_warn_set: assert property (CMP_BUCK_BELOW90[*5]
        |-> STATUS_REGISTER_ZERO[1]) else $error("uv warn missing");
    a_uv_warn_hold: assert property ((!CMP_BUCK_ABOVE94)[*4]
        ##0 STATUS_REGISTER_ZERO[1] |=> STATUS_REGISTER_ZERO[1])
        else $error("uv warn dropped early");
    a_uv_fault_stop: assert property (CMP_BUCK_BELOW80[*5]
        |-> !BUCK_EN && STATUS_REGISTER_ZERO[2] && !CURRENT_LIMIT_FAULT_OUT_N)
        else $error("uv fault not taken");
    a_ov_buck_stop: assert property (CMP_SUPPLY_OV_STOP[*5] |-> !BUCK_EN)
        else $error("buck on above ov stop");
    a_in_uv_stop: assert property (CMP_BUCK_IN_UV[*5]
        |-> !BUCK_EN && STATUS_REGISTER_ZERO[2]) else $error("in uv missed");
    a_fb_held_stop: assert property (CMP_FB_EXT_HELD[*5] |-> !BUCK_EN)
        else $error("buck on with fb held");
    a_link_quiet: assert property (!MSG_PENDING && STATUS_LINK_PIN_OE_N
        && quiet_q >= 20'(QUIET_CYC) |=> STATUS_LINK_PIN_OE_N)
        else $error("link pulled with no message");
    a_link_refused: assert property ((!STATUS_LINK_PIN_I)[*3]
        ##0 STATUS_LINK_PIN_OE_N |=> STATUS_LINK_PIN_OE_N)
        else $error("sent over host");
    a_pull_zero: assert property (!STATUS_LINK_PIN_OE_N
        |-> !STATUS_LINK_PIN_O) else $error("link driven high");
    c_ldo5_up: cover property ($rose(LDO5_EN));
    c_frame_start: cover property ($fell(STATUS_LINK_PIN_OE_N));
    c_fault_pin: cover property ($fell(CURRENT_LIMIT_FAULT_OUT_N));
endmodule

// ===== verif/prss_host.sv
// host end of the open-drain status link, including the pull-up
// measures the first low pulse the device sends after each reset
`timescale 1ns/100ps
module prss_host (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    input wire logic hold_low,
    output logic wire_level,
    output logic [15:0] low_len,
    output logic len_valid
);
    logic [15:0] cnt_q;
    logic dev_low;
    assign dev_low = !pin_oe_n && !pin_o;
    // pull-up: high unless a party pulls down; host may talk
    assign wire_level = !(dev_low || hold_low);
    // no brown-out flag on this link, so no configuration resend
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            low_len <= 16'h0000;
            len_valid <= 1'b0;
        end else if (dev_low) begin
            cnt_q <= cnt_q + 16'h0001;
        end else begin
            if (cnt_q != 16'h0000 && !len_valid) begin
                low_len <= cnt_q;
                len_valid <= 1'b1;
            end
            cnt_q <= 16'h0000;
        end
    end
endmodule

// ===== verif/prss_top_tb.sv
// self-checking bench for prss_top with a host model on the status link
// needs the design header and package compiled first
`timescale 1ns/100ps
`include "prss_regs.svh"
module prss_top_tb;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b0, sleep = 1'b0, amp = 1'b0;
    logic oc = 1'b0, b90 = 1'b0, a94 = 1'b1, b80 = 1'b0, ov = 1'b0;
    logic in_uv = 1'b0, fb = 1'b0, band = 1'b0, low_cp = 1'b0;
    logic hold = 1'b0;
    logic pin_i, pin_o, oe_n, ldo5, ldo12, buck, cp, flt_n, pend, len_valid;
    logic [7:0] st;
    logic [15:0] low_len;
    int mismatches = 0;
    int compares = 0;
    always #5 clk = ~clk;
    prss_top #(.BUCK_START_CYC(20)) i_dut (.CLK(clk), .RST(rst),
        .CLK_EN(1'b1), .CHIP_ENABLE(ce), .SLEEP_REQ(sleep),
        .VARIANT_AMP(amp), .CMP_BUCK_OC(oc), .CMP_BUCK_BELOW90(b90),
        .CMP_BUCK_ABOVE94(a94), .CMP_BUCK_BELOW80(b80),
        .CMP_SUPPLY_OV_STOP(ov), .CMP_BUCK_IN_UV(in_uv),
        .CMP_FB_EXT_HELD(fb), .CMP_SUPPLY_12V_BAND(band),
        .CMP_SUPPLY_LOW_CP(low_cp), .STATUS_LINK_PIN_I(pin_i),
        .STATUS_LINK_PIN_O(pin_o), .STATUS_LINK_PIN_OE_N(oe_n),
        .LDO5_EN(ldo5), .LDO12_EN(ldo12), .BUCK_EN(buck),
        .CHARGE_PUMP_EN(cp), .CURRENT_LIMIT_FAULT_OUT_N(flt_n),
        .STATUS_REGISTER_ZERO(st), .MSG_PENDING(pend));
    prss_host i_host (.clk(clk), .rst(rst), .pin_o(pin_o), .pin_oe_n(oe_n),
        .hold_low(hold), .wire_level(pin_i), .low_len(low_len),
        .len_valid(len_valid));
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp,
        input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic sig(input int k);
        return (k == 0) ? ldo5 : (k == 1) ? buck : len_valid;
    endfunction
    // a wait that runs out ends the run at once
    task automatic wait_for(input int k, input int lim, input string nm);
        for (int i = 0; i < lim && sig(k) !== 1'b1; i++) cyc(1);
        chk(nm, 16'h0001, {15'h0000, sig(k)});
        if (sig(k) !== 1'b1) stop_test();
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        {ce, sleep, oc, b90, b80, ov, in_uv, fb, band, low_cp, hold} <= '0;
        a94 <= 1'b1;
        cyc(10);
        rst <= 1'b0;
        cyc(1);
        chk("reset outs", 16'h0006, {ldo5, ldo12, buck, cp, flt_n, oe_n, pend});
        chk("reset status", 16'h0000, {8'h00, st});
    endtask
    initial begin
        do_reset();
        wait_for(0, 200, "standby ldo5");
        chk("standby ldo12", 16'h0000, {15'h0000, ldo12});
        @(posedge clk) {ce, low_cp} <= 2'b11;
        cyc(6);
        chk("run ldo12 pump", 16'h0003, {14'h0000, ldo12, cp});
        @(posedge clk) band <= 1'b1;
        cyc(6);
        chk("band pump", 16'h0000, {15'h0000, cp});
        @(posedge clk) {hold, oc} <= 2'b11;
        cyc(6);
        chk("oc warn", 16'h0101, {7'h00, buck, st});
        @(posedge clk) {b90, a94} <= 2'b10;
        cyc(40);
        chk("refused", 16'h0003, {14'h0000, oe_n, pend});
        @(posedge clk) {hold, b90} <= 2'b00;
        cyc(6);
        chk("uv warn held", 16'h0003, {8'h00, st});
        @(posedge clk) a94 <= 1'b1;
        cyc(6);
        chk("uv warn clear", 16'h0001, {8'h00, st});
        wait_for(2, 11000, "frame seen");
        chk("start bit", 16'(`PRSS_BIT_CYC), low_len);
        chk("queue kept", 16'h0001, {15'h0000, pend});
        @(posedge clk) oc <= 1'b0;
        cyc(6);
        chk("oc clear", 16'h0000, {8'h00, st});
        do_reset();
        @(posedge clk) ce <= 1'b1;
        wait_for(0, 200, "run ldo5");
        @(posedge clk) b80 <= 1'b1;
        cyc(6);
        chk("uv fault", 16'h0008, {7'h00, buck, st[6:0], flt_n});
        @(posedge clk) b80 <= 1'b0;
        cyc(6);
        chk("fault latch", 16'h0001, {15'h0000, st[2]});
        @(posedge clk) {ce, sleep} <= 2'b01;
        cyc(6);
        chk("sleep rails", 16'h0000, {14'h0000, ldo5, ldo12});
        @(posedge clk) {sleep, amp} <= 2'b01;
        cyc(30);
        chk("amp standby", 16'h0000, {15'h0000, ldo5});
        for (int k = 0; k < 3; k++) begin
            do_reset();
            @(posedge clk) ce <= 1'b1;
            wait_for(1, 200, "buck up");
            @(posedge clk) {ov, in_uv, fb} <= 3'b100 >> k;
            cyc(6);
            chk("buck stop", 16'h0000, {15'h0000, buck});
            if (k == 1) chk("in uv", 16'h0001, {15'h0000, st[2]});
        end
        stop_test();
    end
    initial begin
        cyc(60000);
        mismatches++;
        stop_test();
    end
endmodule
bind prss_top prss_checker #(.BUCK_START_CYC(BUCK_START_CYC)) i_chk (
    .CLK(CLK), .RST(RST), .CHIP_ENABLE(CHIP_ENABLE), .SLEEP_REQ(SLEEP_REQ),
    .VARIANT_AMP(VARIANT_AMP), .CMP_BUCK_OC(CMP_BUCK_OC),
    .CMP_BUCK_BELOW90(CMP_BUCK_BELOW90), .CMP_BUCK_ABOVE94(CMP_BUCK_ABOVE94),
    .CMP_BUCK_BELOW80(CMP_BUCK_BELOW80),
    .CMP_SUPPLY_OV_STOP(CMP_SUPPLY_OV_STOP), .CMP_BUCK_IN_UV(CMP_BUCK_IN_UV),
    .CMP_FB_EXT_HELD(CMP_FB_EXT_HELD),
    .CMP_SUPPLY_12V_BAND(CMP_SUPPLY_12V_BAND),
    .STATUS_LINK_PIN_I(STATUS_LINK_PIN_I),
    .STATUS_LINK_PIN_O(STATUS_LINK_PIN_O),
    .STATUS_LINK_PIN_OE_N(STATUS_LINK_PIN_OE_N), .LDO5_EN(LDO5_EN),
    .LDO12_EN(LDO12_EN), .BUCK_EN(BUCK_EN), .CHARGE_PUMP_EN(CHARGE_PUMP_EN),
    .CURRENT_LIMIT_FAULT_OUT_N(CURRENT_LIMIT_FAULT_OUT_N),
    .STATUS_REGISTER_ZERO(STATUS_REGISTER_ZERO), .MSG_PENDING(MSG_PENDING));
